// ==== hdl/accel_link_pkg.sv ====
// Purpose: Shared constants for the sensor serial slave and its host.
// Assumes: hclk at 100 MHz, link clock derived by the host divider.
// Notes: Register map offsets are the host's own command registers.
`default_nettype none
package accel_link_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned LINK_HZ_FAST = 400_000;
  // Quarter period of the link clock, rounded down to whole cycles
  localparam int unsigned QUARTER_CYC = CLK_HZ / (LINK_HZ_FAST * 4);
  localparam logic [5:0] ADDR_UPPER = 6'h0e;
  localparam int unsigned SUB_INC_BIT = 7;
  localparam int unsigned NREGS = 128;
  // Device register reset values
  localparam logic [7:0] CTRL1_RST = 8'h07;
  localparam logic [7:0] THS_RST = 8'h02;
  localparam logic [6:0] CTRL1_IDX = 7'h20;
  localparam logic [6:0] CTRL2_IDX = 7'h21;
  localparam logic [6:0] STATUS_IDX = 7'h27;
  localparam logic [6:0] SRC_IDX = 7'h31;
  localparam logic [6:0] THS_IDX = 7'h32;
  localparam logic [6:0] OUT_LO_IDX = 7'h29;
  localparam int unsigned SIM_BIT = 0;
  localparam int unsigned SAMPLE_DIV = 2048;
  // Host command registers over AHB-Lite, byte addresses
  localparam logic [7:0] H_CTRL = 8'h00;
  localparam logic [7:0] H_SUB = 8'h04;
  localparam logic [7:0] H_WDATA = 8'h08;
  localparam logic [7:0] H_RDATA = 8'h0c;
  localparam logic [7:0] H_STATUS = 8'h10;
  localparam logic [7:0] H_DEVADDR = 8'h14;
  localparam logic [31:0] H_DEVADDR_RST = 32'h0000_001c;
endpackage
`default_nettype wire

// ==== hdl/accel_link_if.sv ====
// Purpose: Wires between host and sensor: select pad, clock, data lines.
// Assumes: Open drain lines resolved here from output enables.
// Notes: Output enable low means the module pulls the line low.
`default_nettype none
interface accel_link_if;
  logic sel_pad;
  logic scl_oe_n;
  logic host_sda_oe_n;
  logic dev_sda_oe_n;
  logic dev_sdo;
  logic scl;
  logic sda;
  assign scl = scl_oe_n;
  assign sda = host_sda_oe_n & dev_sda_oe_n;
  modport host (output sel_pad, output scl_oe_n, output host_sda_oe_n, input scl, input sda);
  modport dev (input sel_pad, input scl, input sda, output dev_sda_oe_n, output dev_sdo);
endinterface
`default_nettype wire

// ==== hdl/accel_i2c_register_slave.sv ====
// Purpose: Sensor end: two-wire register slave with sample logic.
// Assumes: Bus lines and select pad are asynchronous to hclk.
// Notes: Address low bit comes from the aux data-out pad strap.
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`default_nettype none
module accel_i2c_register_slave
  import accel_link_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = SAMPLE_DIV
)
(
  // System
  input wire logic hclk,
  input wire logic hresetn,
  // Link
  accel_link_if.dev link,
  // Strap and events
  input wire logic aux_pad,
  input wire logic [7:0] trim_value,
  output logic sample_ready,
  output logic int_out,
  output logic spi_three_wire
);
  initial
  begin
    if (SAMPLE_CYC < 2)
    begin
      $error("SAMPLE_CYC too small");
    end
  end

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_SUB = 3'b010,
    S_WDATA = 3'b011,
    S_RDATA = 3'b100,
    S_ACK = 3'b101,
    S_MACK = 3'b110,
    S_BOOT = 3'b111
  } dev_state_t;

  ////////////////////////////////////////////////////////////////////
  // Synchronisers and edge detection
  logic [1:0] scl_s_r, sda_s_r, sel_s_r, aux_s_r;
  logic scl_d_r, sda_d_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_s_r <= 2'b11;
      sda_s_r <= 2'b11;
      sel_s_r <= 2'b11;
      aux_s_r <= 2'b00;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_s_r <= {scl_s_r[0], link.scl};
      sda_s_r <= {sda_s_r[0], link.sda};
      sel_s_r <= {sel_s_r[0], link.sel_pad};
      aux_s_r <= {aux_s_r[0], aux_pad};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end
  wire scl_i = scl_s_r[1];
  wire sda_i = sda_s_r[1];
  wire i2c_mode = sel_s_r[1];
  wire scl_rise = scl_i & ~scl_d_r;
  wire scl_fall = ~scl_i & scl_d_r;
  // Both conditions qualified by clock high on both samples
  wire start_det = i2c_mode & scl_i & scl_d_r & sda_d_r & ~sda_i;
  wire stop_det = i2c_mode & scl_i & scl_d_r & ~sda_d_r & sda_i;
  // Edge detection on oversampled lines keeps fast mode in margin

  ////////////////////////////////////////////////////////////////////
  // Register file and protocol state
  logic [7:0] regs_r [NREGS];
  dev_state_t state_r, ret_r;
  logic [7:0] shift_r;
  logic [3:0] bit_r;
  logic [6:0] ptr_r;
  logic inc_r, rd_r, sda_oe_n_r, boot_done_r;
  logic [6:0] boot_idx_r;
  logic [6:0] my_addr_r;
  logic [15:0] samp_cnt_r;
  logic [7:0] sample_r;

  wire [6:0] ptr_nxt = inc_r ? ptr_r + 7'd1 : ptr_r;
  wire addr_match = shift_r[7:1] == my_addr_r;
  wire samp_tick = samp_cnt_r == 16'(SAMPLE_CYC - 1);
  wire [7:0] ctrl1 = regs_r[CTRL1_IDX];
  wire [7:0] ths = regs_r[THS_IDX];
  wire samp_new = samp_tick & ctrl1[6];
  wire evt_new = samp_new & (sample_r > ths) & (|ctrl1[2:0]);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= S_BOOT;
      ret_r <= S_IDLE;
      shift_r <= 8'h00;
      bit_r <= 4'h0;
      ptr_r <= 7'h00;
      inc_r <= 1'b0;
      rd_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
      boot_done_r <= 1'b0;
      boot_idx_r <= 7'h00;
      my_addr_r <= {ADDR_UPPER, 1'b0};
      samp_cnt_r <= 16'h0000;
      sample_r <= 8'h00;
      sample_ready <= 1'b0;
      int_out <= 1'b0;
      for (int i = 0; i < NREGS; i++)
      begin
        regs_r[i] <= 8'h00;
      end
    end
    else if (state_r == S_BOOT)
    begin
      // Trim copy, one register per cycle before the port opens
      regs_r[boot_idx_r] <= (boot_idx_r < CTRL1_IDX) ? trim_value : 8'h00;
      boot_idx_r <= boot_idx_r + 7'd1;
      if (boot_idx_r == 7'h7f)
      begin
        regs_r[CTRL1_IDX] <= CTRL1_RST;
        regs_r[THS_IDX] <= THS_RST;
        my_addr_r <= {ADDR_UPPER, aux_s_r[1]};
        boot_done_r <= 1'b1;
        state_r <= S_IDLE;
      end
    end
    else
    begin
      // Sample generator stands in for the measurement chain
      samp_cnt_r <= samp_tick ? 16'h0000 : samp_cnt_r + 16'h0001;
      if (samp_new)
      begin
        sample_r <= sample_r + 8'h01;
        regs_r[OUT_LO_IDX] <= sample_r;
        regs_r[STATUS_IDX][3] <= 1'b1;
        sample_ready <= 1'b1;
        if (evt_new)
        begin
          regs_r[SRC_IDX][6] <= 1'b1;
          int_out <= 1'b1;
        end
      end
      if (!i2c_mode || stop_det)
      begin
        state_r <= S_IDLE;
        sda_oe_n_r <= 1'b1;
      end
      else if (start_det)
      begin
        // Also covers the repeated start
        state_r <= S_ADDR;
        bit_r <= 4'h0;
        sda_oe_n_r <= 1'b1;
      end
      else
      begin
        // Stalls only stretch the wait for the next edge
        unique case (state_r)
          S_IDLE, S_BOOT:
          begin
            sda_oe_n_r <= 1'b1;
          end
          S_ADDR, S_SUB, S_WDATA:
          begin
            if (scl_rise)
            begin
              shift_r <= {shift_r[6:0], sda_i};
              bit_r <= bit_r + 4'h1;
            end
            if (scl_fall && bit_r == 4'h8)
            begin
              bit_r <= 4'h0;
              if (state_r == S_ADDR && !addr_match)
              begin
                state_r <= S_IDLE;
              end
              else
              begin
                sda_oe_n_r <= 1'b0;
                state_r <= S_ACK;
                if (state_r == S_ADDR)
                begin
                  rd_r <= shift_r[0];
                  ret_r <= shift_r[0] ? S_RDATA : S_SUB;
                end
                else if (state_r == S_SUB)
                begin
                  ptr_r <= shift_r[6:0];
                  inc_r <= shift_r[SUB_INC_BIT];
                  ret_r <= S_WDATA;
                end
                else
                begin
                  // Host must avoid reserved slots
                  regs_r[ptr_r] <= shift_r;
                  // A new sample in the same cycle wins over the clear
                  if (ptr_r == CTRL1_IDX && !samp_new)
                  begin
                    sample_ready <= 1'b0;
                  end
                  ptr_r <= ptr_nxt;
                  ret_r <= S_WDATA;
                end
              end
            end
          end
          S_ACK:
          begin
            if (scl_fall)
            begin
              sda_oe_n_r <= 1'b1;
              state_r <= ret_r;
              if (ret_r == S_RDATA)
              begin
                shift_r <= {regs_r[ptr_r][6:0], 1'b0};
                sda_oe_n_r <= regs_r[ptr_r][7];
                if (ptr_r == STATUS_IDX && !samp_new)
                begin
                  regs_r[STATUS_IDX][3] <= 1'b0;
                end
                if (ptr_r == SRC_IDX && !evt_new)
                begin
                  regs_r[SRC_IDX] <= 8'h00;
                  int_out <= 1'b0;
                end
                ptr_r <= ptr_nxt;
                bit_r <= 4'h1;
              end
            end
          end
          S_RDATA:
          begin
            if (scl_fall)
            begin
              if (bit_r == 4'h8)
              begin
                sda_oe_n_r <= 1'b1;
                state_r <= S_MACK;
                bit_r <= 4'h0;
              end
              else
              begin
                sda_oe_n_r <= shift_r[7];
                shift_r <= {shift_r[6:0], 1'b0};
                bit_r <= bit_r + 4'h1;
              end
            end
          end
          S_MACK:
          begin
            if (scl_rise)
            begin
              // Missing host acknowledge ends the read
              state_r <= sda_i ? S_IDLE : S_ACK;
              ret_r <= S_RDATA;
            end
          end
          default:
          begin
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

  assign link.dev_sda_oe_n = sda_oe_n_r;
  assign link.dev_sdo = aux_s_r[1];
  assign spi_three_wire = regs_r[CTRL2_IDX][SIM_BIT];
endmodule
`default_nettype wire

// ==== hdl/accel_host_master.sv ====
// Purpose: Host end: AHB-Lite controlled two-wire master.
// Assumes: Single word transfers, slave always OKAY.
// Notes: Each command is one byte transaction; software sequences frames.
`default_nettype none
module accel_host_master
  import accel_link_pkg::*;
(
  // System
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Link
  accel_link_if.host link
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_START = 3'b001,
    H_BIT = 3'b010,
    H_STOP = 3'b011,
    H_DONE = 3'b100
  } host_state_t;

  ////////////////////////////////////////////////////////////////////
  // Bus slave
  logic ph_wr_r;
  logic [7:0] ph_addr_r;
  wire take = hsel & htrans[1];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr_r <= 1'b0;
      ph_addr_r <= 8'h00;
    end
    else
    begin
      ph_wr_r <= take & hwrite;
      ph_addr_r <= haddr;
    end
  end

  // Control: bit0 go, bit1 start first, bit2 stop after, bit3 read, bit4 no-ack
  logic [4:0] ctrl_r;
  logic [7:0] wdata_r, rdata_r, shift_r;
  logic busy_r, nack_r, go_r;
  logic [6:0] devaddr_r;
  logic [1:0] scl_s_r, sda_s_r;
  host_state_t st_r;
  logic [3:0] bit_r;
  logic [1:0] ph_r;
  logic [7:0] div_r;
  logic scl_oe_r, sda_oe_r;
  wire tick = div_r == 8'(QUARTER_CYC - 1);
  wire scl_i = scl_s_r[1];
  wire sda_i = sda_s_r[1];
  wire wr_ctrl = ph_wr_r && ph_addr_r == H_CTRL;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire [31:0] rd_mux =
    (ph_addr_r == H_CTRL) ? {27'h0, ctrl_r} :
    (ph_addr_r == H_WDATA) ? {24'h0, wdata_r} :
    (ph_addr_r == H_RDATA) ? {24'h0, rdata_r} :
    (ph_addr_r == H_STATUS) ? {30'h0, nack_r, busy_r} :
    (ph_addr_r == H_DEVADDR) ? {25'h0, devaddr_r} : 32'h0000_0000;
  assign hrdata = rd_mux;

  ////////////////////////////////////////////////////////////////////
  // Byte engine
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r <= 5'h00;
      wdata_r <= 8'h00;
      rdata_r <= 8'h00;
      shift_r <= 8'h00;
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      go_r <= 1'b0;
      devaddr_r <= H_DEVADDR_RST[6:0];
      scl_s_r <= 2'b11;
      sda_s_r <= 2'b11;
      st_r <= H_IDLE;
      bit_r <= 4'h0;
      ph_r <= 2'h0;
      div_r <= 8'h00;
      scl_oe_r <= 1'b1;
      sda_oe_r <= 1'b1;
    end
    else
    begin
      scl_s_r <= {scl_s_r[0], link.scl};
      sda_s_r <= {sda_s_r[0], link.sda};
      div_r <= tick ? 8'h00 : div_r + 8'h01;
      if (ph_wr_r && ph_addr_r == H_WDATA)
      begin
        wdata_r <= hwdata[7:0];
      end
      if (ph_wr_r && ph_addr_r == H_DEVADDR)
      begin
        devaddr_r <= hwdata[6:0];
      end
      if (wr_ctrl && !busy_r)
      begin
        ctrl_r <= hwdata[4:0];
        go_r <= hwdata[0];
        busy_r <= hwdata[0];
      end
      if (tick)
      begin
        ph_r <= ph_r + 2'h1;
        unique case (st_r)
          H_IDLE:
          begin
            ph_r <= 2'h0;
            if (go_r)
            begin
              go_r <= 1'b0;
              shift_r <= ctrl_r[3] ? 8'hff : wdata_r;
              bit_r <= 4'h0;
              st_r <= ctrl_r[1] ? H_START : H_BIT;
              nack_r <= 1'b0;
            end
          end
          H_START:
          begin
            // Release, then pull data low while clock high
            unique case (ph_r)
              2'h0: sda_oe_r <= 1'b1;
              2'h1: scl_oe_r <= 1'b1;
              2'h2: sda_oe_r <= 1'b0;
              2'h3:
              begin
                scl_oe_r <= 1'b0;
                st_r <= H_BIT;
              end
            endcase
          end
          H_BIT:
          begin
            unique case (ph_r)
              2'h0:
              begin
                // Ninth bit: host acks a read unless bit4 no-ack is set, releases a write
                if (bit_r == 4'h8)
                begin
                  sda_oe_r <= ctrl_r[3] ? ctrl_r[4] : 1'b1;
                end
                else
                begin
                  sda_oe_r <= ctrl_r[3] ? 1'b1 : shift_r[7];
                end
              end
              2'h1: scl_oe_r <= 1'b1;
              2'h2:
              begin
                // Wait while the far end holds the clock low
                if (!scl_i)
                begin
                  ph_r <= 2'h2;
                end
                else if (bit_r == 4'h8)
                begin
                  nack_r <= sda_i;
                end
                else
                begin
                  shift_r <= {shift_r[6:0], sda_i};
                end
              end
              2'h3:
              begin
                scl_oe_r <= 1'b0;
                bit_r <= bit_r + 4'h1;
                if (bit_r == 4'h8)
                begin
                  rdata_r <= shift_r;
                  st_r <= ctrl_r[2] ? H_STOP : H_DONE;
                end
              end
            endcase
          end
          H_STOP:
          begin
            unique case (ph_r)
              2'h0: sda_oe_r <= 1'b0;
              2'h1: scl_oe_r <= 1'b1;
              2'h2: sda_oe_r <= 1'b1;
              2'h3: st_r <= H_DONE;
            endcase
          end
          H_DONE:
          begin
            busy_r <= 1'b0;
            st_r <= H_IDLE;
          end
          default:
          begin
            st_r <= H_IDLE;
          end
        endcase
      end
    end
  end

  assign link.sel_pad = 1'b1;
  assign link.scl_oe_n = scl_oe_r;
  assign link.host_sda_oe_n = sda_oe_r;
endmodule
`default_nettype wire

// ==== testbench/accel_link_assertions.sv ====
// Purpose: Protocol checks on the two-wire link between host and sensor.
// Assumes: Both ends change the lines with hclk, so hclk sampling is exact.
// Notes: Own address is rebuilt from the strap echo via dev_sdo.
`default_nettype none
module accel_link_assertions
  import accel_link_pkg::*;
(
  // System
  input wire logic hclk,
  input wire logic hresetn,
  // Link
  input wire logic sel_pad,
  input wire logic scl_oe_n,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic dev_sdo,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q_r, sda_q_r, busy_r, first_r, sel_r, rw_r, nak_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  wire start_w = scl && scl_q_r && sda_q_r && !sda;
  wire stop_w = scl && scl_q_r && !sda_q_r && sda;
  wire rise_w = scl && !scl_q_r;
  wire ninth_w = rise_w && (cnt_r == 4'd8);
  wire own_w = (sh_r[7:1] == {ADDR_UPPER, dev_sdo});
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  // Bus tracker: counts bits from the master's clock rises
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      busy_r <= 1'b0;
      first_r <= 1'b0;
      sel_r <= 1'b0;
      rw_r <= 1'b0;
      nak_r <= 1'b0;
      cnt_r <= 4'd0;
      sh_r <= 8'h00;
    end
    else
    begin
      scl_q_r <= scl;
      sda_q_r <= sda;
      busy_r <= start_w | (busy_r & ~stop_w);
      if (start_w | stop_w)
      begin
        cnt_r <= 4'd0;
        first_r <= start_w;
        sel_r <= 1'b0;
        nak_r <= 1'b0;
      end
      else if (ninth_w)
      begin
        cnt_r <= 4'd0;
        first_r <= 1'b0;
        nak_r <= sel_r & rw_r & ~first_r & sda;
        if (first_r)
        begin
          sel_r <= own_w;
          rw_r <= sh_r[0];
        end
      end
      else if (rise_w)
      begin
        cnt_r <= cnt_r + 4'd1;
        sh_r <= {sh_r[6:0], sda};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sel_high_a: assert property (sel_pad)
    else $error("select pad not high");
  idle_release_a: assert property (!busy_r |-> dev_sda_oe_n)
    else $error("sensor drives data while bus idle");
  high_stable_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
    else $error("sensor changed data while clock high");
  addr_ack_a: assert property (ninth_w && first_r && own_w |-> !sda)
    else $error("own address not acknowledged");
  addr_nak_a: assert property (ninth_w && first_r && !own_w |-> dev_sda_oe_n)
    else $error("foreign address acknowledged");
  write_ack_a: assert property (ninth_w && !first_r && sel_r && !rw_r |-> !sda)
    else $error("written byte not acknowledged");
  read_release_a: assert property (ninth_w && !first_r && sel_r && rw_r |-> dev_sda_oe_n)
    else $error("sensor holds data in read ack slot");
  host_release_a: assert property (ninth_w && (first_r || (sel_r && !rw_r)) |->
    host_sda_oe_n)
    else $error("host holds data in ack slot");
  nak_hold_a: assert property (nak_r |-> dev_sda_oe_n)
    else $error("sensor drives data after host no-ack");
endmodule
`default_nettype wire

// ==== testbench/test_accel_i2c_register_slave.sv ====
// Purpose: Drives the host over AHB-Lite and checks sensor register traffic.
// Assumes: Host answers with zero wait states; sensor boots in 128 cycles.
// Notes: Sample period shortened so the ready flag shows quickly.
`default_nettype none
module test_accel_i2c_register_slave
  import accel_link_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] GO = 5'h01;
  localparam logic [4:0] BEG = 5'h02;
  localparam logic [4:0] FIN = 5'h04;
  localparam logic [4:0] RD = 5'h08;
  localparam logic [4:0] NK = 5'h10;
  // Strap held low, so the address low bit is zero
  localparam logic [7:0] AW = {ADDR_UPPER, 2'b00};
  localparam logic [7:0] AR = {ADDR_UPPER, 2'b01};
  localparam logic [7:0] TRIM = 8'hd2;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, aux_pad;
  logic sample_ready, int_out, spi_three_wire;
  logic [7:0] haddr, trim_value;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  int num_errors = 0;
  int cmp_count = 0;
  accel_link_if accel_link_if_i ();
  accel_host_master accel_host_master_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(accel_link_if_i));
  accel_i2c_register_slave #(.SAMPLE_CYC(16)) accel_i2c_register_slave_i (.hclk(hclk),
    .hresetn(hresetn), .link(accel_link_if_i), .aux_pad(aux_pad), .trim_value(trim_value),
    .sample_ready(sample_ready), .int_out(int_out), .spi_three_wire(spi_three_wire));
  accel_link_assertions accel_link_assertions_i (.hclk(hclk), .hresetn(hresetn),
    .sel_pad(accel_link_if_i.sel_pad), .scl_oe_n(accel_link_if_i.scl_oe_n),
    .host_sda_oe_n(accel_link_if_i.host_sda_oe_n),
    .dev_sda_oe_n(accel_link_if_i.dev_sda_oe_n), .dev_sdo(accel_link_if_i.dev_sdo),
    .scl(accel_link_if_i.scl), .sda(accel_link_if_i.sda));
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic give_up();
    num_errors++;
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1)
      give_up();
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // One byte over the link; busy is polled with a bound, a hang ends the run
  task automatic xfer(input logic [4:0] c, input logic [7:0] b, input logic nk_exp);
    logic [31:0] s;
    int n;
    ahb(1'b1, H_WDATA, {24'h0, b}, s);
    ahb(1'b1, H_CTRL, {27'h0, c | GO}, s);
    n = 0;
    do
    begin
      ahb(1'b0, H_STATUS, 32'h0, s);
      n++;
    end while (s[0] !== 1'b0 && n < 4000);
    if (s[0] !== 1'b0)
      give_up();
    if (!c[3])
      chk({31'h0, s[1]}, {31'h0, nk_exp});
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d0, input logic [7:0] d1,
    input int n);
    xfer(BEG, AW, 1'b0);
    xfer(5'h00, sub, 1'b0);
    xfer(n == 1 ? FIN : 5'h00, d0, 1'b0);
    if (n > 1)
      xfer(FIN, d1, 1'b0);
  endtask
  task automatic rd(input logic [7:0] sub, input logic [7:0] e0, input logic [7:0] e1,
    input int n);
    logic [31:0] r;
    xfer(BEG, AW, 1'b0);
    xfer(5'h00, sub, 1'b0);
    xfer(BEG, AR, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      xfer(i == n - 1 ? RD | FIN | NK : RD, 8'h00, 1'b0);
      ahb(1'b0, H_RDATA, 32'h0, r);
      chk(r, {24'h0, i == 0 ? e0 : e1});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial
  begin
    logic [31:0] r;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    aux_pad = 1'b0;
    trim_value = TRIM;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, H_DEVADDR, 32'h0, r);
    chk(r, H_DEVADDR_RST);
    ahb(1'b1, 8'h40, 32'hffff_ffff, r);
    ahb(1'b0, 8'h40, 32'h0, r);
    chk(r, 32'h0000_0000);
    // Boot must finish before the first frame
    repeat (140) @(posedge hclk);
    wr({1'b0, THS_IDX}, 8'h6c, 8'h00, 1);
    rd({1'b0, THS_IDX}, 8'h6c, 8'h00, 1);
    rd({1'b1, CTRL1_IDX}, CTRL1_RST, 8'h00, 2);
    rd(8'h00, TRIM, 8'h00, 1);
    xfer(BEG | FIN, {ADDR_UPPER, 2'b10}, 1'b1);
    rd({1'b0, THS_IDX}, 8'h6c, 8'h00, 1);
    chk({31'h0, sample_ready}, 32'h0);
    chk({31'h0, int_out}, 32'h0);
    wr({1'b1, CTRL1_IDX}, 8'h47, 8'h01, 2);
    chk({31'h0, spi_three_wire}, 32'h1);
    for (int i = 0; i < 200 && sample_ready !== 1'b1; i++)
      @(posedge hclk);
    chk({31'h0, sample_ready}, 32'h1);
    rd({1'b0, CTRL1_IDX}, 8'h47, 8'h00, 1);
    // Sample count has long passed the threshold by now
    chk({31'h0, int_out}, 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
